// ---- verilog/id_router_pkg.sv ----
// Package with the address map, register offsets, reset values and timing counts of the router.
package id_router_pkg;

    localparam logic [7:0]  ID_RADIO          = 8'h01;
    localparam logic [7:0]  ID_LOCAL          = 8'hC7;
    localparam logic [7:0]  ID_IO_BASE        = 8'hC8;
    localparam logic [7:0]  ID_DISPLAY        = 8'hC9;
    localparam logic [7:0]  OWN_ADDR_MIN      = 8'h01;
    localparam logic [7:0]  OWN_ADDR_MAX      = 8'hF6;

    localparam logic [15:0] REG_WINDOW_FIRST  = 16'h1966;
    localparam logic [15:0] REG_WINDOW_COUNT  = 16'h1967;
    localparam logic [15:0] RST_WINDOW_FIRST  = 16'h000B;
    localparam logic [15:0] RST_WINDOW_COUNT  = 16'h0032;
    localparam logic [15:0] WINDOW_COUNT_MAX  = 16'h0064;

    localparam logic [2:0]  ROUTE_NONE        = 3'h0;
    localparam logic [2:0]  ROUTE_RADIO       = 3'h1;
    localparam logic [2:0]  ROUTE_LOCAL       = 3'h2;
    localparam logic [2:0]  ROUTE_IO_BASE     = 3'h3;
    localparam logic [2:0]  ROUTE_DISPLAY     = 3'h4;
    localparam logic [2:0]  ROUTE_WIRELESS    = 3'h5;
    localparam logic [2:0]  ROUTE_WIRED       = 3'h6;

    localparam int          CLK_PERIOD_PS     = 5000;
    localparam int          TICK_TIME_US      = 1000;
    localparam int          TICK_CYCLES       = (TICK_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int          TIMEOUT_DEFAULT_S = 5;
    localparam logic [15:0] RST_TIMEOUT_MS    = 16'(TIMEOUT_DEFAULT_S * 1000);

    typedef enum logic {ST_IDLE, ST_WAIT} poll_state_e;

endpackage

// ---- verilog/modbus_id_router_timeout.sv ----
// Request router, slave-port filter and response timer of the dual-role field bus controller.
`timescale 1ns/1ps
`default_nettype none
module modbus_id_router_timeout
    import id_router_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
)(
    input  wire logic        REF_CLK_I,
    input  wire logic        RESETN_I,
    input  wire logic        CE_I,
    input  wire logic        TREE_RADIO_FITTED_I,
    input  wire logic        MB_REQ_VALID_I,
    input  wire logic [7:0]  MB_REQ_ID_I,
    input  wire logic        MB_REQ_WRITE_I,
    input  wire logic [15:0] MB_REQ_REG_I,
    input  wire logic [15:0] MB_REQ_DATA_I,
    input  wire logic        MB_RESP_I,
    input  wire logic        TIMEOUT_LOAD_I,
    input  wire logic [15:0] TIMEOUT_MS_I,
    input  wire logic [7:0]  OWN_SLAVE_ADDRESS_I,
    input  wire logic        SP_REQ_VALID_I,
    input  wire logic [7:0]  SP_REQ_ID_I,
    output logic             MB_READY_O,
    output logic             MB_SENT_O,
    output logic [2:0]       MB_ROUTE_O,
    output logic             MB_DONE_O,
    output logic             MB_LOST_O,
    output logic             RADIO_RDATA_VALID_O,
    output logic [15:0]      RADIO_RDATA_O,
    output logic             SP_LOCAL_ACCESS_O
);

    typedef struct packed {
        poll_state_e state;
        logic        ready;
        logic        sent;
        logic [2:0]  route;
        logic        done;
        logic        lost;
        logic        rvalid;
        logic [15:0] rdata;
        logic        sp_hit;
        logic [15:0] first;
        logic [15:0] count;
        logic [15:0] tmo_ms;
        logic [15:0] ms_cnt;
        logic [17:0] pre;
    } router_s;

    router_s q;
    router_s next_q;
    logic    rst_meta;
    logic    rst_n;

    // Window membership, inclusive of first and first plus count minus one.
    function automatic logic in_window(input logic [7:0] id, input logic [15:0] first,
                                       input logic [15:0] count);
        logic [16:0] last_excl;
        last_excl = {1'b0, first} + {1'b0, count};
        in_window = ({9'h000, id} >= {1'b0, first}) && ({9'h000, id} < last_excl);
    endfunction

    // Destination for a master-bus address.
    function automatic logic [2:0] route_of(input logic [7:0] id, input logic fitted,
                                            input logic [15:0] first, input logic [15:0] count);
        if (id == ID_RADIO)
            route_of = ROUTE_RADIO;
        else if (id == ID_LOCAL)
            route_of = ROUTE_LOCAL;
        else if (id == ID_IO_BASE)
            route_of = ROUTE_IO_BASE;
        else if (id == ID_DISPLAY)
            route_of = ROUTE_DISPLAY;
        else if (fitted && in_window(id, first, count))
            route_of = ROUTE_WIRELESS;
        else
            route_of = ROUTE_WIRED;
    endfunction

    // Reset release through two flip-flops.
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_comb
    begin
        next_q        = q;
        next_q.sent   = 1'b0;
        next_q.done   = 1'b0;
        next_q.lost   = 1'b0;
        next_q.rvalid = 1'b0;
        // The slave port is checked every cycle with CE_I high, whatever the master side is doing.
        next_q.sp_hit = SP_REQ_VALID_I && (SP_REQ_ID_I == OWN_SLAVE_ADDRESS_I)
                        && (OWN_SLAVE_ADDRESS_I >= OWN_ADDR_MIN)
                        && (OWN_SLAVE_ADDRESS_I <= OWN_ADDR_MAX);
        if (TIMEOUT_LOAD_I)
            next_q.tmo_ms = TIMEOUT_MS_I;
        case (q.state)
            ST_IDLE:
            begin
                if (MB_REQ_VALID_I)
                begin
                    next_q.sent   = 1'b1;
                    next_q.route  = route_of(MB_REQ_ID_I, TREE_RADIO_FITTED_I, q.first, q.count);
                    next_q.state  = ST_WAIT;
                    next_q.ms_cnt = 16'h0000;
                    next_q.pre    = 18'h00000;
                    // The tree radio holds its window registers as 16-bit holding registers.
                    if (MB_REQ_ID_I == ID_RADIO && TREE_RADIO_FITTED_I)
                    begin
                        if (MB_REQ_WRITE_I && MB_REQ_REG_I == REG_WINDOW_FIRST)
                            next_q.first = MB_REQ_DATA_I;
                        else if (MB_REQ_WRITE_I && MB_REQ_REG_I == REG_WINDOW_COUNT)
                            next_q.count = (MB_REQ_DATA_I > WINDOW_COUNT_MAX) ?
                                           WINDOW_COUNT_MAX : MB_REQ_DATA_I;
                        else if (!MB_REQ_WRITE_I && MB_REQ_REG_I == REG_WINDOW_FIRST)
                        begin
                            next_q.rvalid = 1'b1;
                            next_q.rdata  = q.first;
                        end
                        else if (!MB_REQ_WRITE_I && MB_REQ_REG_I == REG_WINDOW_COUNT)
                        begin
                            next_q.rvalid = 1'b1;
                            next_q.rdata  = q.count;
                        end
                    end
                end
            end
            ST_WAIT:
            begin
                if (MB_RESP_I)
                begin
                    next_q.done  = 1'b1;
                    next_q.state = ST_IDLE;
                end
                else if (q.ms_cnt >= q.tmo_ms)
                begin
                    next_q.lost  = 1'b1;
                    next_q.state = ST_IDLE;
                end
                else if (q.pre == 18'(TICK_COUNT - 1))
                begin
                    next_q.pre    = 18'h00000;
                    next_q.ms_cnt = q.ms_cnt + 16'h0001;
                end
                else
                    next_q.pre = q.pre + 18'h00001;
            end
            default:
                next_q.state = ST_IDLE;
        endcase
        next_q.ready = (next_q.state == ST_IDLE);
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q        <= '0;
            q.state  <= ST_IDLE;
            q.ready  <= 1'b1;
            q.first  <= RST_WINDOW_FIRST;
            q.count  <= RST_WINDOW_COUNT;
            q.tmo_ms <= RST_TIMEOUT_MS;
        end
        else if (CE_I)
            q <= next_q;
    end

    assign MB_READY_O          = q.ready;
    assign MB_SENT_O           = q.sent;
    assign MB_ROUTE_O          = q.route;
    assign MB_DONE_O           = q.done;
    assign MB_LOST_O           = q.lost;
    assign RADIO_RDATA_VALID_O = q.rvalid;
    assign RADIO_RDATA_O       = q.rdata;
    assign SP_LOCAL_ACCESS_O   = q.sp_hit;

    a_radio_route: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        CE_I && q.state == ST_IDLE && MB_REQ_VALID_I && MB_REQ_ID_I == ID_RADIO
        |=> MB_ROUTE_O == ROUTE_RADIO && MB_SENT_O)
        else $error("Address 1 not routed to radio.");

    a_internal_route: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        CE_I && q.state == ST_IDLE && MB_REQ_VALID_I && MB_REQ_ID_I == ID_DISPLAY
        |=> MB_ROUTE_O == ROUTE_DISPLAY)
        else $error("Address 201 not routed to display.");

    a_window_forward: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        CE_I && q.state == ST_IDLE && MB_REQ_VALID_I && TREE_RADIO_FITTED_I
        && MB_REQ_ID_I > ID_RADIO && MB_REQ_ID_I < ID_LOCAL
        && in_window(MB_REQ_ID_I, q.first, q.count) |=> MB_ROUTE_O == ROUTE_WIRELESS)
        else $error("Window address not forwarded.");

    a_window_end: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        CE_I && q.state == ST_IDLE && MB_REQ_VALID_I && MB_REQ_ID_I > ID_RADIO
        && MB_REQ_ID_I < ID_LOCAL && {8'h00, MB_REQ_ID_I} == q.first + q.count
        |=> MB_ROUTE_O == ROUTE_WIRED)
        else $error("Address past window end forwarded.");

    a_count_limit: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        q.count <= WINDOW_COUNT_MAX)
        else $error("Window count above limit.");

    a_first_write: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        CE_I && q.state == ST_IDLE && MB_REQ_VALID_I && TREE_RADIO_FITTED_I
        && MB_REQ_ID_I == ID_RADIO && MB_REQ_WRITE_I && MB_REQ_REG_I == REG_WINDOW_FIRST
        |=> q.first == $past(MB_REQ_DATA_I))
        else $error("First address write lost.");

    a_slave_filter: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        CE_I && SP_REQ_VALID_I && SP_REQ_ID_I != OWN_SLAVE_ADDRESS_I |=> !SP_LOCAL_ACCESS_O)
        else $error("Foreign slave-port address accepted.");

    a_wait_holds: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        CE_I && q.state == ST_WAIT && !MB_RESP_I && q.ms_cnt < q.tmo_ms
        |=> q.state == ST_WAIT && !MB_LOST_O)
        else $error("Wait ended before timeout.");

    a_lost_cause: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        MB_LOST_O && $past(CE_I) |-> MB_READY_O && $past(q.state) == ST_WAIT
        && $past(q.ms_cnt) >= $past(q.tmo_ms))
        else $error("Lost pulse without expired wait.");

endmodule
`default_nettype wire

// ---- verif/wired_slave_model.sv ----
// Wired slave on the master bus that answers each sent request after a fixed delay, unless mute_i is high.
`timescale 1ns/1ps
`default_nettype none
module wired_slave_model
#(
    parameter int DELAY = 3
)(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic sent_i,
    input  wire logic mute_i,
    output logic      resp_o
);
    int cnt;
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt <= 0;
            resp_o <= 1'b0;
        end
        else
        begin
            resp_o <= (cnt == 1) && !mute_i;
            cnt <= sent_i ? DELAY : ((cnt > 0) ? cnt - 1 : 0);
        end
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench of the request router, slave-port filter and response timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import id_router_pkg::*;
    localparam int TICK = 4;
    logic        clk = 1'b0, rst_n = 1'b0, fitted = 1'b1, valid = 1'b0, wr = 1'b0;
    logic        tload = 1'b0, sp_valid = 1'b0, mute = 1'b0, ce = 1'b1, resp;
    logic [7:0]  id = 8'h00, own = 8'h05, sp_id = 8'h00;
    logic [15:0] rg = 16'h0000, dt = 16'h0000, tms = 16'h0000, rdata;
    logic        ready, sent, done, lost, rvalid, sp_acc;
    logic [2:0]  route;
    int          mismatches = 0, check_count = 0, n;
    logic [7:0]  ids [9] = '{8'h01, 8'hC7, 8'hC8, 8'hC9, 8'h0B, 8'h3C, 8'h3D, 8'h0A, 8'h00};
    logic [2:0]  rts [9] = '{ROUTE_RADIO, ROUTE_LOCAL, ROUTE_IO_BASE, ROUTE_DISPLAY,
        ROUTE_WIRELESS, ROUTE_WIRELESS, ROUTE_WIRED, ROUTE_WIRED, ROUTE_WIRED};
    logic [7:0]  owns [5] = '{8'h05, 8'h05, 8'hF6, 8'hF7, 8'h00};
    logic [7:0]  spids [5] = '{8'h05, 8'h06, 8'hF6, 8'hF7, 8'h00};
    logic        spexp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    always #2.5 clk = ~clk;
    modbus_id_router_timeout #(.TICK_COUNT(TICK)) i_dut (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .TREE_RADIO_FITTED_I(fitted),
        .MB_REQ_VALID_I(valid), .MB_REQ_ID_I(id), .MB_REQ_WRITE_I(wr), .MB_REQ_REG_I(rg),
        .MB_REQ_DATA_I(dt), .MB_RESP_I(resp), .TIMEOUT_LOAD_I(tload), .TIMEOUT_MS_I(tms),
        .OWN_SLAVE_ADDRESS_I(own), .SP_REQ_VALID_I(sp_valid), .SP_REQ_ID_I(sp_id),
        .MB_READY_O(ready), .MB_SENT_O(sent), .MB_ROUTE_O(route), .MB_DONE_O(done),
        .MB_LOST_O(lost), .RADIO_RDATA_VALID_O(rvalid), .RADIO_RDATA_O(rdata),
        .SP_LOCAL_ACCESS_O(sp_acc));
    wired_slave_model i_slave (.clk_i(clk), .rst_n_i(rst_n), .sent_i(sent), .mute_i(mute),
        .resp_o(resp));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Issues one master request, checks its routing and waits for done or lost.
    task automatic req(input logic [7:0] i, input logic w, input logic [15:0] r,
                       input logic [15:0] d, input logic [2:0] er, input logic el);
        logic ev;
        ev = (i == ID_RADIO) && !w && fitted && (r == REG_WINDOW_FIRST || r == REG_WINDOW_COUNT);
        @(negedge clk);
        id = i;
        wr = w;
        rg = r;
        dt = d;
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        check({15'h0, sent}, 16'h0001);
        check({13'h0, route}, {13'h0, er});
        check({15'h0, rvalid}, {15'h0, ev});
        for (n = 0; n < 30000 && done !== 1'b1 && lost !== 1'b1; n++)
            @(negedge clk);
        if (n == 30000)
        begin
            mismatches++;
            tally_and_finish();
        end
        check({15'h0, lost}, {15'h0, el});
        check({15'h0, done}, {15'h0, !el});
        check({15'h0, ready}, 16'h0001);
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check({15'h0, ready}, 16'h0001);
        check({13'h0, route}, {13'h0, ROUTE_NONE});
        for (int k = 0; k < 9; k++)
            req(ids[k], 1'b0, 16'h0000, 16'h0000, rts[k], 1'b0);
        req(8'h01, 1'b0, REG_WINDOW_FIRST, 16'h0000, ROUTE_RADIO, 1'b0);
        check(rdata, 16'h000B);
        req(8'h01, 1'b0, REG_WINDOW_COUNT, 16'h0000, ROUTE_RADIO, 1'b0);
        check(rdata, 16'h0032);
        req(8'h01, 1'b1, REG_WINDOW_FIRST, 16'h0046, ROUTE_RADIO, 1'b0);
        req(8'h01, 1'b1, REG_WINDOW_COUNT, 16'h00C8, ROUTE_RADIO, 1'b0);
        req(8'h01, 1'b0, REG_WINDOW_COUNT, 16'h0000, ROUTE_RADIO, 1'b0);
        check(rdata, WINDOW_COUNT_MAX);
        req(8'h46, 1'b0, 16'h0001, 16'h0000, ROUTE_WIRELESS, 1'b0);
        req(8'hA9, 1'b0, 16'h0001, 16'h0000, ROUTE_WIRELESS, 1'b0);
        req(8'hAA, 1'b0, 16'h0001, 16'h0000, ROUTE_WIRED, 1'b0);
        req(8'h45, 1'b0, 16'h0001, 16'h0000, ROUTE_WIRED, 1'b0);
        fitted = 1'b0;
        req(8'h46, 1'b0, 16'h0001, 16'h0000, ROUTE_WIRED, 1'b0);
        req(8'h01, 1'b0, REG_WINDOW_FIRST, 16'h0000, ROUTE_RADIO, 1'b0);
        fitted = 1'b1;
        mute = 1'b1;
        req(8'h05, 1'b0, 16'h0001, 16'h0000, ROUTE_WIRED, 1'b1);
        check({15'h0, n >= 5000 * TICK && n <= 5000 * TICK + 5002}, 16'h0001);
        tms = 16'h0003;
        tload = 1'b1;
        @(negedge clk);
        tload = 1'b0;
        req(8'h05, 1'b0, 16'h0001, 16'h0000, ROUTE_WIRED, 1'b1);
        check({15'h0, n >= 3 * TICK && n <= 3 * TICK + 5}, 16'h0001);
        mute = 1'b0;
        req(8'h06, 1'b0, 16'h0001, 16'h0000, ROUTE_WIRED, 1'b0);
        sp_valid = 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            own = owns[k];
            sp_id = spids[k];
            @(negedge clk);
            check({15'h0, sp_acc}, {15'h0, spexp[k]});
        end
        own = 8'h05;
        sp_id = 8'h05;
        @(negedge clk);
        check({15'h0, sp_acc}, 16'h0001);
        ce = 1'b0;
        sp_valid = 1'b0;
        @(negedge clk);
        check({15'h0, sp_acc}, 16'h0001);
        ce = 1'b1;
        @(negedge clk);
        check({15'h0, sp_acc}, 16'h0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
